/* hdl/ivr_pkg.sv */
// constants, layouts and carrier types of the interrupt vector resolver
// assumes one system clock, synchronous reset, avalon-mm register access
// Function
// - primary table starts at word 000004h
// - five traps plus up to 118 sources
// - winning source selects its own vector
// - each entry is a 24-bit routine address
// - at equal level, lower vector wins by natural order
// - alt_table_enable redirects every vector fetch
// - alternate table follows primary, same layout
// - alternate address is base plus vector offset
// - reset bypasses resolver, entry address zero
// - fixed trap priorities fifteen down to eleven
// - ecc double error raises vector two
// - soft hard trap shares vector two, gated
// - request number maps flag, enable, priority
// - primary address is 4 plus twice vector
// - clock calendar uses vector 70, request 62
// - ecc single error uses vector 116
// - logic cell one uses vector 104
// - flags set by source, cleared by software
// - three-bit field picks one of eight levels
// - acceptance latches vector and new level
// - cpu level seven or more blocks users
package ivr_pkg;
   localparam int          NUM_IRQ      = 118;
   localparam int          NUM_TRAP     = 8;
   localparam int          FLAG_WORDS   = 8;
   localparam int          PRIO_WORDS   = 30;
   localparam int          NUM_FIELDS   = 4 * PRIO_WORDS;
   // request numbers that exist; all others are reserved
   localparam logic [127:0] IRQ_IMPL    = 128'h0020_5463_CC30_210F_FC66_7833_E31F_FFFF;
   localparam logic [23:0] TABLE_OFFSET = 24'h000004;
   localparam logic [23:0] RESET_ENTRY  = 24'h000000;
   localparam logic [23:0] PRIMARY_END  = 24'h000100;
   localparam logic [23:0] ALT_BASE_DEF = 24'h000400; // last boot page, plain default
   // trap vectors and their fixed levels
   localparam logic [7:0]  VEC_OSC      = 8'h00;
   localparam logic [7:0]  VEC_ADDR     = 8'h01;
   localparam logic [7:0]  VEC_HARD     = 8'h02;
   localparam logic [7:0]  VEC_STACK    = 8'h03;
   localparam logic [7:0]  VEC_MATH     = 8'h04;
   localparam logic [7:0]  USER_VEC0    = 8'h08;
   localparam logic [3:0]  LVL_OSC      = 4'hF;
   localparam logic [3:0]  LVL_ADDR     = 4'hE;
   localparam logic [3:0]  LVL_HARD     = 4'hD;
   localparam logic [3:0]  LVL_STACK    = 4'hC;
   localparam logic [3:0]  LVL_MATH     = 4'hB;
   localparam logic [3:0]  LVL_USER_MAX = 4'h7;
   // register byte addresses
   localparam logic [7:0]  OFS_FLAG     = 8'h00;
   localparam logic [7:0]  OFS_EN       = 8'h20;
   localparam logic [7:0]  OFS_PRIO     = 8'h40;
   localparam logic [7:0]  OFS_CTL_ONE  = 8'hC0;
   localparam logic [7:0]  OFS_CTL_TWO  = 8'hC4;
   localparam logic [7:0]  OFS_CTL_FOUR = 8'hCC;
   localparam logic [7:0]  OFS_TAKEN    = 8'hD0;
   localparam logic [7:0]  OFS_CPU_LVL  = 8'hD4;
   // field positions
   localparam int          B_OSC        = 1;
   localparam int          B_STACK      = 2;
   localparam int          B_ADDR       = 3;
   localparam int          B_MATH       = 4;
   localparam int          B_ALT_EN     = 8;
   localparam int          B_SOFT_EN    = 13;
   localparam int          B_SOFT_TRAP  = 0;
   localparam int          B_ECC_TRAP   = 1;
   localparam logic [15:0] CTL_ONE_MASK = 16'h001E;
   localparam logic [15:0] CTL_TWO_MASK = 16'h2100;
   localparam logic [15:0] CTL_FOUR_MSK = 16'h0003;
   localparam logic [15:0] RST_WORD     = 16'h0000;

   // hardware trap events, one-cycle pulses
   typedef struct packed {
      logic osc_fail;
      logic addr_error;
      logic stack_error;
      logic divide_zero_error;
      logic ecc_double_bit_trap;
   } ivr_trap_type;

   // request presented to the cpu core
   typedef struct packed {
      logic        valid;
      logic [7:0]  vector;
      logic [3:0]  level;
      logic [23:0] fetch_addr;
   } ivr_req_type;
endpackage : ivr_pkg

/* hdl/ivr_pick.sv */
// natural-order picker over user requests
// assumes pend and prio come from flops on the same clock
`timescale 1ns/1ps
`default_nettype none
module ivr_pick #(
   parameter int N = 118
) (
   input  wire logic [N-1:0]   pend,
   input  wire logic [3*N-1:0] prio,
   output logic                found,
   output logic [6:0]          idx,
   output logic [2:0]          level
);
   // refuse widths the 7-bit index cannot serve
   if (N < 1 || N > 128) begin : g_bad_n
      $error("ivr_pick: N out of range");
   end

   // walk downward so that an equal level at a lower number takes over
   always_comb begin
      found = 1'b0;
      idx   = 7'h00;
      level = 3'h0;
      for (int i = N - 1; i >= 0; i--) begin
         if (pend[i] && (!found || prio[3*i +: 3] >= level)) begin
            found = 1'b1;
            idx   = 7'(i);
            level = prio[3*i +: 3];
         end
      end
   end
endmodule : ivr_pick
`default_nettype wire

/* hdl/ivr_resolver.sv */
// trap and interrupt resolver with avalon-mm register slave
// assumes sources, traps and cpu level come from logic on clk_sys
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ivr_resolver #(
   parameter logic [23:0] ALT_TABLE_BASE = ivr_pkg::ALT_BASE_DEF
) (
   input  wire logic                clk_sys,
   input  wire logic                rst,
   input  wire logic [7:0]          address,
   input  wire logic                read,
   input  wire logic                write,
   input  wire logic [31:0]         writedata,
   output logic [31:0]              readdata,
   output logic                     waitrequest,
   input  wire logic [117:0]        irq_source,
   input  wire ivr_pkg::ivr_trap_type trap_event,
   input  wire logic [3:0]          cpu_priority_level,
   input  wire logic                irq_accept,
   output ivr_pkg::ivr_req_type     cpu_req,
   output logic [23:0]              reset_entry
);
   localparam int NI = ivr_pkg::NUM_IRQ;

   // refuse a base that would overlap the primary table
   if (ALT_TABLE_BASE < ivr_pkg::PRIMARY_END) begin : g_bad_base
      $error("ivr_resolver: alternate table overlaps primary");
   end

   // storage, reserved positions pruned by the mask
   logic [127:0] flag_q;
   logic [127:0] flag_d;
   logic [127:0] en_q;
   logic [127:0] en_d;
   logic [2:0]   prio_q [ivr_pkg::NUM_FIELDS];
   logic [15:0]  ctl_one_q;
   logic [15:0]  ctl_two_q;
   logic [15:0]  ctl_four_q;
   logic [15:0]  taken_q;
   logic         ack_q;
   logic [31:0]  readdata_q;
   ivr_pkg::ivr_req_type req_q;

   // bus decode
   wire        bus_req  = read | write;
   wire        wr_go    = write & ack_q;
   wire [5:0]  widx     = address[7:2];
   wire        hit_flag = (address[7:5] == 3'h0);
   wire        hit_en   = (address[7:5] == 3'h1);
   wire        hit_prio = (address >= ivr_pkg::OFS_PRIO) && (address < ivr_pkg::OFS_CTL_ONE);
   wire [2:0]  fwd      = widx[2:0];
   wire [4:0]  pwd      = 5'(widx - 6'h10);
   wire        wr_one   = wr_go && address == ivr_pkg::OFS_CTL_ONE;
   wire        wr_two   = wr_go && address == ivr_pkg::OFS_CTL_TWO;
   wire        wr_four  = wr_go && address == ivr_pkg::OFS_CTL_FOUR;

   // one wait state gives the read mux a full cycle
   assign waitrequest = bus_req & ~ack_q;
   assign readdata    = readdata_q;
   assign reset_entry = ivr_pkg::RESET_ENTRY;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= bus_req & ~ack_q;
      end
   end

   // flag and enable words, hardware set wins over a software clear
   always_comb begin
      flag_d = flag_q;
      en_d   = en_q;
      if (wr_go && hit_flag) begin
         flag_d[16*fwd +: 16] = writedata[15:0];
      end
      if (wr_go && hit_en) begin
         en_d[16*fwd +: 16] = writedata[15:0];
      end
      flag_d = (flag_d | {10'h000, irq_source}) & ivr_pkg::IRQ_IMPL;
      en_d   = en_d & ivr_pkg::IRQ_IMPL;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         flag_q <= '0;
         en_q   <= '0;
      end else begin
         flag_q <= flag_d;
         en_q   <= en_d;
      end
   end

   // priority fields: four per word at 4*(n mod 4); reserved stay zero
   genvar g;
   generate
      for (g = 0; g < ivr_pkg::NUM_FIELDS; g++) begin : g_prio
         always_ff @(posedge clk_sys) begin
            if (rst || !ivr_pkg::IRQ_IMPL[g]) begin
               prio_q[g] <= 3'h0;
            end else if (wr_go && hit_prio && pwd == 5'(g / 4)) begin
               prio_q[g] <= writedata[4*(g%4) +: 3];
            end
         end
      end
   endgenerate

   // trap control words; hardware trap events set bits, set wins
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctl_one_q  <= ivr_pkg::RST_WORD;
         ctl_two_q  <= ivr_pkg::RST_WORD;
         ctl_four_q <= ivr_pkg::RST_WORD;
      end else begin
         ctl_one_q  <= ((wr_one ? writedata[15:0] : ctl_one_q)
                       | {11'h000, trap_event.divide_zero_error, trap_event.addr_error,
                          trap_event.stack_error, trap_event.osc_fail, 1'b0})
                       & ivr_pkg::CTL_ONE_MASK;
         ctl_two_q  <= (wr_two ? writedata[15:0] : ctl_two_q) & ivr_pkg::CTL_TWO_MASK;
         ctl_four_q <= ((wr_four ? writedata[15:0] : ctl_four_q)
                       | {14'h0000, trap_event.ecc_double_bit_trap, 1'b0})
                       & ivr_pkg::CTL_FOUR_MSK;
      end
   end

   // read mux for the addressed word
   function automatic logic [15:0] prio_word(input logic [4:0] w);
      logic [15:0] r;
      r = 16'h0000;
      for (int k = 0; k < 4; k++) begin
         if (4*w + k < ivr_pkg::NUM_FIELDS) begin
            r[4*k +: 3] = prio_q[4*w + k];
         end
      end
      return r;
   endfunction : prio_word

   // always_comb sees the array reads inside the function, a plain assign would not
   logic [15:0] prio_rd;
   always_comb begin
      prio_rd = prio_word(pwd);
   end

   wire [15:0] rd_word =
      hit_flag ? flag_q[16*fwd +: 16] :
      hit_en   ? en_q[16*fwd +: 16] :
      hit_prio ? prio_rd :
      (address == ivr_pkg::OFS_CTL_ONE)  ? ctl_one_q :
      (address == ivr_pkg::OFS_CTL_TWO)  ? ctl_two_q :
      (address == ivr_pkg::OFS_CTL_FOUR) ? ctl_four_q :
      (address == ivr_pkg::OFS_TAKEN)    ? taken_q :
      (address == ivr_pkg::OFS_CPU_LVL)  ? {12'h000, cpu_priority_level} :
      16'h0000; // unmapped reads zero, writes dropped

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         readdata_q <= 32'h0000_0000;
      end else if (read && !ack_q) begin
         readdata_q <= {16'h0000, rd_word};
      end
   end

   // user candidates: flag, enable and level above the cpu
   logic [NI-1:0]   pend;
   logic [3*NI-1:0] prio_flat;
   generate
      for (g = 0; g < NI; g++) begin : g_pend
         assign prio_flat[3*g +: 3] = prio_q[g];
         assign pend[g] = flag_q[g] & en_q[g] & ({1'b0, prio_q[g]} > cpu_priority_level);
      end
   endgenerate

   logic       user_found;
   logic [6:0] user_idx;
   logic [2:0] user_lvl;

   ivr_pick #(
      .N     (NI)
   ) u_pick (
      .pend  (pend),
      .prio  (prio_flat),
      .found (user_found),
      .idx   (user_idx),
      .level (user_lvl)
   );

   // traps by fixed level, each needs a level above the cpu
   wire t_osc   = ctl_one_q[ivr_pkg::B_OSC]   && ivr_pkg::LVL_OSC   > cpu_priority_level;
   wire t_addr  = ctl_one_q[ivr_pkg::B_ADDR]  && ivr_pkg::LVL_ADDR  > cpu_priority_level;
   wire t_hard  = (ctl_four_q[ivr_pkg::B_ECC_TRAP]
                  || (ctl_four_q[ivr_pkg::B_SOFT_TRAP] && ctl_two_q[ivr_pkg::B_SOFT_EN]))
                  && ivr_pkg::LVL_HARD > cpu_priority_level;
   wire t_stack = ctl_one_q[ivr_pkg::B_STACK] && ivr_pkg::LVL_STACK > cpu_priority_level;
   wire t_math  = ctl_one_q[ivr_pkg::B_MATH]  && ivr_pkg::LVL_MATH  > cpu_priority_level;
   wire alt_en  = ctl_two_q[ivr_pkg::B_ALT_EN];

   // winner: traps outrank users, lower vector first among traps
   logic [7:0] win_vec;
   logic [3:0] win_lvl;
   logic       win_ok;
   always_comb begin
      win_ok  = 1'b1;
      win_vec = ivr_pkg::VEC_OSC;
      win_lvl = ivr_pkg::LVL_OSC;
      if (t_osc) begin
         win_vec = ivr_pkg::VEC_OSC;
         win_lvl = ivr_pkg::LVL_OSC;
      end else if (t_addr) begin
         win_vec = ivr_pkg::VEC_ADDR;
         win_lvl = ivr_pkg::LVL_ADDR;
      end else if (t_hard) begin
         win_vec = ivr_pkg::VEC_HARD;
         win_lvl = ivr_pkg::LVL_HARD;
      end else if (t_stack) begin
         win_vec = ivr_pkg::VEC_STACK;
         win_lvl = ivr_pkg::LVL_STACK;
      end else if (t_math) begin
         win_vec = ivr_pkg::VEC_MATH;
         win_lvl = ivr_pkg::LVL_MATH;
      end else if (user_found) begin
         win_vec = ivr_pkg::USER_VEC0 + {1'b0, user_idx};
         win_lvl = {1'b0, user_lvl};
      end else begin
         win_ok  = 1'b0;
      end
   end

   // table address; 24-bit entry there holds the routine start
   wire [23:0] tbl_base  = alt_en ? ALT_TABLE_BASE : 24'h000000;
   wire [23:0] fetch_nxt = tbl_base + ivr_pkg::TABLE_OFFSET
                           + {15'h0000, win_vec, 1'b0};

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         req_q <= '0;
      end else begin
         req_q <= '{valid: win_ok, vector: win_vec, level: win_lvl, fetch_addr: fetch_nxt};
      end
   end

   assign cpu_req = req_q;

   // acceptance latches vector and new level for software
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         taken_q <= ivr_pkg::RST_WORD;
      end else if (irq_accept && req_q.valid) begin
         taken_q <= {4'h0, req_q.level, req_q.vector};
      end
   end

   // one-cycle copies so a vector can be traced to the state that chose it
   logic [NI-1:0]   pend_q;
   logic [3*NI-1:0] prio_flat_q;
   always_ff @(posedge clk_sys) begin
      pend_q      <= pend;
      prio_flat_q <= prio_flat;
   end

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_bus_wait;
      bus_req && !ack_q;
   endsequence

   sequence s_bus_done;
      !waitrequest ##1 !ack_q;
   endsequence

   a_bus_answer: assert property (s_bus_wait |=> s_bus_done)
      else $error("bus answer not in one wait state");

   a_reserved_zero: assert property ((flag_q & ~ivr_pkg::IRQ_IMPL) == '0
      && (en_q & ~ivr_pkg::IRQ_IMPL) == '0)
      else $error("reserved flag or enable stored");

   a_flag_set: assert property (irq_source[62] |=> flag_q[62])
      else $error("source pulse did not set its flag");

   a_flag_hold: assert property (flag_q[96] && !(wr_go && hit_flag) |=> flag_q[96])
      else $error("flag dropped without software clear");

   a_osc_first: assert property (ctl_one_q[ivr_pkg::B_OSC] && cpu_priority_level < 4'hF
      |=> cpu_req.valid && cpu_req.vector == 8'h00 && cpu_req.level == 4'hF)
      else $error("oscillator trap not taken first");

   a_user_block: assert property (cpu_priority_level >= 4'h7
      && ctl_one_q == 16'h0000 && ctl_four_q == 16'h0000
      |=> !cpu_req.valid)
      else $error("user request passed a blocking level");

   a_soft_gate: assert property (ctl_one_q == 16'h0000 && ctl_four_q == 16'h0001
      && !ctl_two_q[ivr_pkg::B_SOFT_EN] && !user_found |=> !cpu_req.valid)
      else $error("soft hard trap taken while disabled");

   a_fetch_addr: assert property (cpu_req.valid |-> cpu_req.fetch_addr
      == ($past(alt_en) ? ALT_TABLE_BASE : 24'h000000) + 24'h000004
         + {15'h0000, cpu_req.vector, 1'b0})
      else $error("fetch address does not match vector");

   a_user_source: assert property (cpu_req.valid && cpu_req.vector >= 8'h08
      |-> pend_q[7'(cpu_req.vector - 8'h08)]
         && {1'b0, prio_flat_q[3*(cpu_req.vector - 8'h08) +: 3]} == cpu_req.level)
      else $error("user vector not from a pending source");

   a_taken_latch: assert property (irq_accept && cpu_req.valid
      |=> taken_q == {4'h0, $past(cpu_req.level), $past(cpu_req.vector)})
      else $error("taken register not latched");

   a_reset_quiet: assert property ($fell(rst) |-> !cpu_req.valid && taken_q == 16'h0000)
      else $error("state not cleared by reset");
endmodule : ivr_resolver
`default_nettype wire

/* bench/ivr_cpu_model.sv */
// cpu core stand-in that takes each new vector the resolver offers
// assumes cpu_req comes from ivr_resolver on the same clk_sys
`timescale 1ns/1ps
`default_nettype none
module ivr_cpu_model #(
   parameter logic [23:0] ALT_BASE = 24'h000400
) (
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   input  wire ivr_pkg::ivr_req_type cpu_req,
   input  wire logic                 hold,
   output logic                      irq_accept,
   output logic [23:0]               isr_addr
);
   localparam logic [23:0] DEF_ISR = 24'h000F00; // reset handler, plain default
   logic [23:0] last_fetch_q;
   logic        took_q;
   logic        fresh;
   logic        take;

   // software image: alternate mirrors primary, unused slots reset
   function automatic logic [23:0] isr_of(input logic [23:0] a);
      logic [23:0] o;
      logic [7:0]  v;
      o = (a >= ALT_BASE) ? a - ALT_BASE : a;
      v = 8'((o - 24'h000004) >> 1);
      if (v >= 8'h05 && v <= 8'h07) begin
         return DEF_ISR;
      end
      return 24'h001000 + {14'h0000, v, 2'b00};
   endfunction : isr_of

   // a held core is the slow case: acceptance waits until hold drops
   assign fresh = cpu_req.valid & (~took_q | (cpu_req.fetch_addr != last_fetch_q));
   assign take  = fresh & ~hold & ~irq_accept;

   // one accept pulse per new fetch, never two cycles running
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         irq_accept   <= 1'b0;
         took_q       <= 1'b0;
         last_fetch_q <= 24'h000000;
         isr_addr     <= 24'h000000;
      end else begin
         irq_accept <= take;
         if (take) begin
            took_q       <= 1'b1;
            last_fetch_q <= cpu_req.fetch_addr;
            isr_addr     <= isr_of(cpu_req.fetch_addr);
         end
      end
   end
endmodule : ivr_cpu_model
`default_nettype wire

/* bench/ivr_resolver_test.sv */
// self-checking bench for the resolver: avalon accesses, sources, traps
// assumes ivr_pkg, ivr_resolver and ivr_cpu_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module ivr_resolver_test;
   localparam logic [23:0] ALT_B = 24'h000800;
   logic                  clk_sys, rst, read, write, waitrequest;
   logic                  irq_accept, hold, alt;
   logic [7:0]            address;
   logic [31:0]           writedata, readdata;
   logic [117:0]          irq_source;
   logic [3:0]            cpu_priority_level;
   logic [23:0]           reset_entry, isr_addr;
   ivr_pkg::ivr_trap_type trap_event;
   ivr_pkg::ivr_req_type  cpu_req;
   int                    n_fail = 0;
   int                    samples_checked = 0;
   int                    cycles = 0;
   int                    i;
   logic [7:0]            clr_a [5];
   logic [15:0]           clr_v [5];

   ivr_resolver #(.ALT_TABLE_BASE(ALT_B)) DUT (
      .clk_sys(clk_sys), .rst(rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .irq_source(irq_source),
      .trap_event(trap_event), .cpu_priority_level(cpu_priority_level),
      .irq_accept(irq_accept), .cpu_req(cpu_req), .reset_entry(reset_entry)
   );

   ivr_cpu_model #(.ALT_BASE(ALT_B)) cpu (
      .clk_sys(clk_sys), .rst(rst), .cpu_req(cpu_req), .hold(hold),
      .irq_accept(irq_accept), .isr_addr(isr_addr)
   );

   // 100 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // hang guard, well above the few hundred cycles the run needs
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 6000) begin
         n_fail++;
         results();
      end
   end

   task automatic results();
      $display("checks %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results

   task automatic cmp(input logic [36:0] got, input logic [36:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   // avalon read: hold the request until waitrequest is seen low
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk_sys);
      address <= a;
      read    <= 1'b1;
      do @(posedge clk_sys); while (waitrequest !== 1'b0);
      read <= 1'b0;
      cmp({5'h00, readdata}, {21'h000000, exp});
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      address   <= a;
      writedata <= {16'h0000, d};
      write     <= 1'b1;
      do @(posedge clk_sys); while (waitrequest !== 1'b0);
      write <= 1'b0;
   endtask : wr

   task automatic pulse(input logic [117:0] s, input logic [4:0] t);
      @(posedge clk_sys);
      irq_source <= s;
      trap_event <= t;
      @(posedge clk_sys);
      irq_source <= '0;
      trap_event <= '0;
   endtask : pulse

   task automatic lvl(input logic [3:0] l);
      @(posedge clk_sys);
      cpu_priority_level <= l;
   endtask : lvl

   // request check: fetch is table base + 4 + twice the vector
   task automatic chk(input logic v, input logic [7:0] vec, input logic [3:0] l);
      logic [23:0] f;
      f = (alt ? ALT_B : 24'h000000) + 24'h000004 + {15'h0000, vec, 1'b0};
      repeat (3) @(posedge clk_sys);
      if (v)
         cmp(cpu_req, {1'b1, vec, l, f});
      else
         cmp({36'h0, cpu_req.valid}, 37'h0);
   endtask : chk

   // main sequence
   initial begin
      rst = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 8'h00;
      writedata = 32'h0;
      irq_source = '0;
      trap_event = '0;
      cpu_priority_level = 4'h0;
      hold = 1'b1;
      alt = 1'b0;
      clr_a = '{8'hC0, 8'hC0, 8'hCC, 8'hC0, 8'hC0};
      clr_v = '{16'h001C, 16'h0014, 16'h0000, 16'h0010, 16'h0000};
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      cmp(cpu_req, 37'h0);
      cmp({13'h0, reset_entry}, 37'h0);
      rd(8'hD0, 16'h0000);
      rd(8'hF0, 16'h0000);
      rd(8'hB8, 16'h0000);
      // reserved request positions in word 1 must not store
      wr(8'h04, 16'hFFFF);
      rd(8'h04, 16'hE31F);
      wr(8'h04, 16'h0000);
      // clock calendar source, accepted late by a held core
      wr(8'h2C, 16'h4000);
      wr(8'h7C, 16'h0300);
      pulse(118'h1 << 62, 5'h00);
      chk(1'b1, 8'd70, 4'h3);
      rd(8'h0C, 16'h4000);
      @(posedge clk_sys) hold <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rd(8'hD0, 16'h0346);
      wr(8'h0C, 16'h0000);
      chk(1'b0, 8'h00, 4'h0);
      // two sources on equal level, then unequal, then cpu masking
      wr(8'h38, 16'h1001);
      wr(8'hA0, 16'h0705);
      rd(8'hA0, 16'h0005);
      wr(8'hAC, 16'h0005);
      pulse((118'h1 << 96) | (118'h1 << 108), 5'h00);
      chk(1'b1, 8'd104, 4'h5);
      wr(8'hAC, 16'h0006);
      rd(8'hAC, 16'h0006);
      chk(1'b1, 8'd116, 4'h6);
      lvl(4'h6);
      chk(1'b0, 8'h00, 4'h0);
      wr(8'hAC, 16'h0007);
      lvl(4'h7);
      chk(1'b0, 8'h00, 4'h0);
      lvl(4'h5);
      chk(1'b1, 8'd116, 4'h7);
      // alternate table moves every fetch by the same base
      wr(8'hC4, 16'h0100);
      alt = 1'b1;
      chk(1'b1, 8'd116, 4'h7);
      rd(8'hC4, 16'h0100);
      cmp({13'h0, isr_addr}, {13'h0, 24'h0011D0});
      wr(8'hC4, 16'h0000);
      alt = 1'b0;
      wr(8'h18, 16'h0000);
      lvl(4'h0);
      chk(1'b0, 8'h00, 4'h0);
      // all five traps at once, cleared one by one in fixed order
      pulse('0, 5'h1F);
      rd(8'hCC, 16'h0002);
      rd(8'hC0, 16'h001E);
      for (i = 0; i < 5; i++) begin
         chk(1'b1, i[7:0], 4'hF - i[3:0]);
         wr(clr_a[i], clr_v[i]);
      end
      chk(1'b0, 8'h00, 4'h0);
      // software hard trap needs its enable
      wr(8'hC4, 16'h2000);
      wr(8'hCC, 16'h0001);
      chk(1'b1, 8'h02, 4'hD);
      wr(8'hC4, 16'h0000);
      chk(1'b0, 8'h00, 4'h0);
      wr(8'hCC, 16'h0000);
      results();
   end
endmodule : ivr_resolver_test
`default_nettype wire
